// File: design/feature_csr_consts.svh
// offsets, field positions, reset values and timing counts
`ifndef FEATURE_CSR_CONSTS_SVH
`define FEATURE_CSR_CONSTS_SVH

// byte offsets of each feature word: base + 4 * feature index
`define FEAT_BASE_OFFSET     12'h000
`define FEAT_STRIDE          12'h004
// field positions, bit 0 of the word is its msb (bit 31 in verilog)
`define FLD_PRESENCE         31
`define FLD_ONE_SHOT         26
`define FLD_POWER_ON         25
`define FLD_AUTO_SEL         24
`define FLD_VALUE_MSB        11
`define FLD_VALUE_LSB        0
// reset values of the mode bits and value field
`define RST_POWER_ON         1'b0
`define RST_AUTO_SEL         1'b0
`define RST_ONE_SHOT         1'b0
`define RST_VALUE            12'h000
// off state value forced onto the feature
`define OFF_VALUE            12'h000
// one-shot adjustment time in ns and derived cycles at 100 MHz
`define CLK_PERIOD_NS        10
`define ONE_SHOT_TIME_NS     160
`define ONE_SHOT_CYCLES      (`ONE_SHOT_TIME_NS / `CLK_PERIOD_NS)

`endif

// File: design/feature_csr_pkg.sv
// types shared by the feature control register bank
package feature_csr_pkg;

	// feature operating states
	typedef enum logic [1:0] {
		ST_OFF,
		ST_AUTO,
		ST_MANUAL,
		ST_ONE_SHOT
	} feature_state_t;

	// supported state mask layout, one bit per state
	typedef struct packed {
		logic one_shot;
		logic manual;
		logic auto_ok;
		logic off_ok;
	} support_t;

endpackage

// File: design/adjust_if.sv
// request and answer bundle between the bank and one adjuster
`timescale 1ns/1ps
interface adjust_if #(parameter int VW = 12);
	logic          run;
	logic          start;
	logic [VW-1:0] target;
	logic [VW-1:0] seed;
	logic [VW-1:0] level;
	logic          done;
	modport bank (output run, output start, output target, output seed,
		input level, input done);
	modport adj (input run, input start, input target, input seed,
		output level, output done);
endinterface

// File: design/feature_adjuster.sv
// automatic adjustment engine for one feature value
`timescale 1ns/1ps
`include "feature_csr_consts.svh"
module feature_adjuster
	import feature_csr_pkg::*;
#(
	parameter int VW = 12
) (
	input  wire logic clk,
	input  wire logic rst_b,
	adjust_if.adj     port_a
);

	typedef struct packed {
		logic [VW-1:0] level;
		logic [7:0]    count;
		logic          busy;
		logic          done;
	} adj_state_t;

	adj_state_t st_reg;
	adj_state_t st_next;

	// the settle counter is only eight bits wide
	if (VW < 1 || `ONE_SHOT_CYCLES < 1 ||
		`ONE_SHOT_CYCLES > 255) begin : g_bad
		$error("adjuster parameters out of range");
	end

	// step the level one unit toward target each cycle while running
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		if (port_a.start) begin
			st_next.level = port_a.seed;
			st_next.count = 8'(`ONE_SHOT_CYCLES);
			st_next.busy  = 1'b1;
		end else if (port_a.run || st_reg.busy) begin
			if (st_reg.level < port_a.target)
				st_next.level = st_reg.level + VW'(1);
			else if (st_reg.level > port_a.target)
				st_next.level = st_reg.level - VW'(1);
			if (st_reg.busy) begin
				st_next.count = st_reg.count - 8'h01;
				// a one-shot ends after a fixed settle time
				if (st_reg.count == 8'h01) begin
					st_next.busy = 1'b0;
					st_next.done = 1'b1;
				end
			end
		end else begin
			st_next.level = port_a.seed; // track the held value when idle
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign port_a.level = st_reg.level;
	assign port_a.done  = st_reg.done;

endmodule

// File: design/feature_mode_control_csr.sv
// apb register bank of per-feature mode and value control words
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "feature_csr_consts.svh"
// How it works
// - each feature word is 32 bits, msb-first numbering
// - power-on, one-shot, auto select mode bits
// - power off holds fixed value, ignores control
// - power on plus auto adjusts continuously
// - manual state uses software written value
// - one-shot adjusts once, self-clears, stays manual
// - value writes accepted only in manual state
// - presence set means value shows real setting
// - each feature supports its own state subset
module feature_mode_control_csr
	import feature_csr_pkg::*;
#(
	parameter int          NFEAT   = 4,
	parameter int          VW      = 12,
	parameter logic [NFEAT*4-1:0] SUPPORT = '1,
	parameter logic [NFEAT-1:0]   PRESENT = '1
) (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [NFEAT*VW-1:0]   auto_target,
	output logic      [NFEAT*VW-1:0]   feature_value,
	output logic      [NFEAT*2-1:0]    feature_state
);

	// refuse sizes the ten-bit word index and value field cannot hold
	if (NFEAT < 1 || NFEAT > 1024 || VW < 1 || VW > 12) begin : g_bad
		$error("feature bank parameters out of range");
	end

	typedef struct packed {
		logic          power_on;
		logic          auto_sel;
		logic          one_shot;
		logic [VW-1:0] value;
	} feat_t;

	typedef struct packed {
		feat_t [NFEAT-1:0] feat;
		logic [31:0]       rdata;
	} bank_t;

	bank_t bank_reg;
	bank_t bank_next;

	logic [NFEAT-1:0]    adj_done;
	logic [VW-1:0]       adj_level [NFEAT];
	logic                access;
	logic                addr_ok;
	logic [9:0]          idx;

	// apb access phase completes in one cycle, pready is always high
	assign access  = psel && penable;
	assign idx     = paddr[11:2];
	assign addr_ok = (paddr[1:0] == 2'b00) && (int'(idx) < NFEAT);
	assign pready  = 1'b1;
	assign prdata  = bank_reg.rdata;
	assign pslverr = access && !addr_ok;

	// one adjuster per feature, driven by the mode bits
	genvar g;
	generate
		for (g = 0; g < NFEAT; g++) begin : gen_feat
			adjust_if #(.VW(VW)) a_if ();
			feature_state_t st;
			support_t       sup;
			assign sup = support_t'(SUPPORT[g*4 +: 4]);
			always_comb begin
				if (!bank_reg.feat[g].power_on)
					st = ST_OFF;
				else if (bank_reg.feat[g].auto_sel)
					st = ST_AUTO;
				else if (bank_reg.feat[g].one_shot)
					st = ST_ONE_SHOT;
				else
					st = ST_MANUAL;
			end
			assign a_if.run    = (st == ST_AUTO);
			assign a_if.start  = access && pwrite && addr_ok &&
				(int'(idx) == g) && pwdata[`FLD_POWER_ON] &&
				!pwdata[`FLD_AUTO_SEL] && pwdata[`FLD_ONE_SHOT] &&
				sup.one_shot && !bank_reg.feat[g].one_shot;
			assign a_if.target = auto_target[g*VW +: VW];
			assign a_if.seed   = bank_reg.feat[g].value;
			assign adj_done[g]  = a_if.done;
			assign adj_level[g] = a_if.level;
			assign feature_state[g*2 +: 2] = st;
			// off forces the fixed value onto the feature
			assign feature_value[g*VW +: VW] = (st == ST_OFF) ?
				VW'(`OFF_VALUE) : bank_reg.feat[g].value;
			feature_adjuster #(.VW(VW)) u_adj (
				.clk    (clk),
				.rst_b  (rst_b),
				.port_a (a_if.adj)
			);
		end
	endgenerate

	// register update: writes, autonomous value tracking, read capture
	always_comb begin
		logic [31:0] w;
		logic [31:0] r;
		support_t    s;
		logic        manual;
		w = pwdata;
		r = 32'h0000_0000;
		s = support_t'(4'h0);
		manual = 1'b0;
		bank_next = bank_reg;
		for (int i = 0; i < NFEAT; i++) begin
			s = support_t'(SUPPORT[i*4 +: 4]);
			manual = bank_reg.feat[i].power_on &&
				!bank_reg.feat[i].auto_sel && !bank_reg.feat[i].one_shot;
			// automatic results land in the value field so reads are real
			if (bank_reg.feat[i].power_on &&
				(bank_reg.feat[i].auto_sel || bank_reg.feat[i].one_shot))
				bank_next.feat[i].value = adj_level[i];
			if (adj_done[i])
				bank_next.feat[i].one_shot = 1'b0;
			if (access && pwrite && addr_ok && int'(idx) == i) begin
				// power-off, auto and one-shot writes only accepted where that state is supported
				if (w[`FLD_POWER_ON] ? 1'b1 : s.off_ok)
					bank_next.feat[i].power_on = w[`FLD_POWER_ON];
				if (!w[`FLD_AUTO_SEL] || s.auto_ok)
					bank_next.feat[i].auto_sel = w[`FLD_AUTO_SEL];
				// one-shot only arms from manual; an arming write wins over the hardware clear
				if (w[`FLD_ONE_SHOT] && s.one_shot && manual &&
					w[`FLD_POWER_ON] && !w[`FLD_AUTO_SEL])
					bank_next.feat[i].one_shot = 1'b1;
				if (manual && s.manual)
					bank_next.feat[i].value =
						w[`FLD_VALUE_LSB +: VW];
			end
		end
		// read word captured in the setup cycle so it stands at the
		// access edge; in auto it may lag the live value by one step
		if (psel && !penable && !pwrite && addr_ok) begin
			for (int i = 0; i < NFEAT; i++) begin
				if (int'(idx) == i) begin
					r[`FLD_PRESENCE] = PRESENT[i];
					r[`FLD_ONE_SHOT] = bank_reg.feat[i].one_shot;
					r[`FLD_POWER_ON] = bank_reg.feat[i].power_on;
					r[`FLD_AUTO_SEL] = bank_reg.feat[i].auto_sel;
					r[`FLD_VALUE_LSB +: VW] = (!bank_reg.feat[i].power_on) ?
						VW'(`OFF_VALUE) : bank_reg.feat[i].value;
				end
			end
		end
		bank_next.rdata = r;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			bank_reg <= '0;
		else
			bank_reg <= bank_next;
	end

endmodule

// File: bench/feature_csr_assertions.sv
// port checker for the feature register bank
`timescale 1ns/1ps
module feature_csr_assertions #(
	parameter int NFEAT = 4,
	parameter int VW    = 12
) (
	input wire logic                clk,
	input wire logic                rst_b,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic [NFEAT*VW-1:0] auto_target,
	input wire logic [NFEAT*VW-1:0] feature_value,
	input wire logic [NFEAT*2-1:0]  feature_state
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// feature 0 only, the others share its logic
	wire [1:0]    st = feature_state[1:0];
	wire [VW-1:0] v0 = feature_value[VW-1:0];
	a_ready_high: assert property (pready)
		else $error("ready dropped");
	a_bad_addr: assert property (psel && penable &&
		int'(paddr) >= NFEAT*4 |-> pslverr)
		else $error("unmapped access without error");
	a_good_addr: assert property (psel && penable &&
		int'(paddr) < NFEAT*4 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access errored");
	a_off_fixed: assert property (st == 2'h0 |-> v0 == '0)
		else $error("off value not fixed");
	a_manual_hold: assert property (st == 2'h2 && $past(st) == 2'h2
		&& !$past(psel && penable && pwrite) |-> $stable(v0))
		else $error("manual value moved");
	a_auto_step: assert property (st == 2'h1 && $past(st) == 2'h1 |->
		(v0 - $past(v0)) inside {12'h000, 12'h001, 12'hFFF})
		else $error("auto value jumped");
	a_shot_entry: assert property (st == 2'h3 && $past(st) != 2'h3 |->
		$past(st) == 2'h2) else $error("one-shot entered from non-manual");
	a_shot_ends: assert property ($rose(st == 2'h3) |-> ##[1:20] st == 2'h2)
		else $error("one-shot did not return to manual");
endmodule
bind feature_mode_control_csr feature_csr_assertions #(.NFEAT(NFEAT), .VW(VW))
	u_chk (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .auto_target, .feature_value, .feature_state);

// File: bench/tb.sv
// self-checking bench for the feature register bank
`timescale 1ns/1ps
module tb;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr, t, v;
	logic [31:0] pwdata, prdata;
	logic [47:0] auto_target, feature_value;
	logic [7:0]  feature_state;
	logic [31:0] exp_q[$];
	int          miscompares, cmp_count, cycles;
	localparam logic [31:0] PR = 32'h80000000, MAN = 32'h02000000;
	localparam logic [31:0] AUT = 32'h03000000, OS = 32'h06000000;
	feature_mode_control_csr i_dut (.clk, .rst_b, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .auto_target,
		.feature_value, .feature_state);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("%0d compares, %0d mismatches", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one transfer; a read notes its expected word, d, for the monitor
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic err);
		@(posedge clk);
		if (!w)
			exp_q.push_back(d);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1)
			@(posedge clk);
		check({31'h0, pslverr}, {31'h0, err});
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic chk_fv(input logic [11:0] x, input logic [1:0] s);
		check({20'h0, feature_value[11:0]}, {20'h0, x});
		check({30'h0, feature_state[1:0]}, {30'h0, s});
	endtask
	// read data is taken at the very edge where pready ends the access
	always @(posedge clk) begin
		if (psel && penable && !pwrite && pready === 1'h1)
			check(prdata, exp_q.pop_front());
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		{psel, penable, pwrite, rst_b, paddr, pwdata, auto_target} = '0;
		void'($urandom(55));
		repeat (6) @(posedge clk);
		rst_b <= 1'h1;
		apb(1'h0, 12'h000, PR, 1'h0);
		apb(1'h0, 12'h010, 32'h0, 1'h1);
		$display("test reset done");
		v = 12'($urandom);
		apb(1'h1, 12'h000, MAN, 1'h0);
		apb(1'h1, 12'h000, MAN | v, 1'h0);
		apb(1'h0, 12'h000, PR | MAN | v, 1'h0);
		chk_fv(v, 2'h2);
		apb(1'h1, 12'h000, {20'h0, ~v}, 1'h0);
		@(posedge clk);
		chk_fv(12'h000, 2'h0);
		$display("test manual and off done");
		t = 12'($urandom_range(255));
		auto_target <= {36'($urandom), t};
		apb(1'h1, 12'h000, AUT | 32'h5A5, 1'h0);
		for (int n = 0; n < 5000 && feature_value[11:0] !== t; n++)
			@(posedge clk);
		chk_fv(t, 2'h1);
		apb(1'h0, 12'h000, PR | AUT | t, 1'h0);
		apb(1'h1, 12'h000, AUT | {20'h0, ~t}, 1'h0);
		repeat (3) @(posedge clk);
		chk_fv(t, 2'h1);
		$display("test auto done");
		// one-shot walks back from t+3 to the target, then sits in manual
		apb(1'h1, 12'h000, MAN, 1'h0);
		apb(1'h1, 12'h000, MAN | (t + 12'h3), 1'h0);
		apb(1'h1, 12'h000, OS | (t + 12'h3), 1'h0);
		@(posedge clk);
		check({30'h0, feature_state[1:0]}, 32'h3);
		repeat (20) @(posedge clk);
		chk_fv(t, 2'h2);
		apb(1'h0, 12'h000, PR | MAN | t, 1'h0);
		repeat (2) @(posedge clk);
		$display("test one-shot done");
		summarize();
	end
endmodule
